/* File: verilog/dcf_pkg.sv */
// Purpose: Shared constants for the dual-clock style FIFO flag block
// Assumes: AXI4-Lite register access, 32-bit data, word-aligned offsets
// Notes: Offsets are byte addresses
package dcf_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned DEPTH_DEF = 16384;
  localparam int unsigned DATA_W = 9;
  localparam int unsigned ADDR_W = 8;

  // ==========================================================
  // Register map
  localparam logic [7:0] REG_EMPTY_OFS = 8'h00;
  localparam logic [7:0] REG_FULL_OFS = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0c;

  // Status field positions
  localparam int unsigned ST_FALL = 0;
  localparam int unsigned ST_SERIAL = 1;
  localparam int unsigned ST_EMPTY = 2;
  localparam int unsigned ST_FULL = 3;
  localparam int unsigned ST_AE = 4;
  localparam int unsigned ST_AF = 5;
  localparam int unsigned ST_HALF = 6;
  localparam int unsigned ST_OR = 7;
  localparam int unsigned ST_INRDY = 8;

  // ==========================================================
  // Default offsets, picked by the load strap
  localparam int unsigned OFS_PAR_DEF = 127;
  localparam int unsigned OFS_SER_DEF = 1023;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Register write channel states
  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } dcf_wr_state_e;
endpackage

/* File: verilog/dcf_sync2.sv */
// Purpose: Two register stages for pointers and flags
// Assumes: Single clock
// Notes: First stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module dcf_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // ==========================================================
  // Two stages
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_q <= RST;
      s2_q <= RST;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule
`default_nettype wire

/* File: verilog/dcf_store.sv */
// Purpose: Word storage of the FIFO
// Assumes: One write port, one combinational read port
// Notes: Flip-flops, no reset on data
`timescale 1ns/100ps
`default_nettype none
module dcf_store #(
  parameter int unsigned W = 9,
  parameter int unsigned DEPTH = 16384,
  parameter int unsigned AW = $clog2(DEPTH)
) (
  // Clock
  input wire logic clock,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  // ==========================================================
  // Storage, data only so no reset
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule
`default_nettype wire

/* File: verilog/dcf_fifo.sv */
// Purpose: FIFO with standard and fall-through timing and status flags
// Assumes: Writer and reader share one clock; straps stable through reset
// Notes: Offsets and status over AXI4-Lite
// How it works
// - Mode strap caught at reset release
// - Standard mode: every word needs read enable
// - Fall-through: first word shows after three edges
// - Write enable low stores input word
// - Empty flag rises after first write
// - Almost-empty rises at offset plus one
// - Half-full falls at half depth plus one
// - Almost-full falls at depth minus offset
// - Full flag falls at depth words
// - Writes ignored while full
// - First read from full releases full
// - Almost-full and half-full release below threshold
// - Almost-empty falls at offset words
// - Empty falls after last read
// - Reads ignored while empty
// - Empty and full through two stages
// - Fall-through uses output and input ready
// - Default offsets 127 or 1023 by strap
// - Output ready follows first write, last read
// - Input ready off at depth plus one
// - Fall-through almost-empty at offset plus two
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo #(
  parameter int unsigned DEPTH = dcf_pkg::DEPTH_DEF,
  parameter int unsigned W = dcf_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Straps
  input wire logic mode_select_serial_in,
  input wire logic load_select_n,
  // Write side
  input wire logic wr_en_n,
  input wire logic [W-1:0] wr_data,
  // Read side
  input wire logic rd_en_n,
  output logic [W-1:0] read_data_out,
  // Flags
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic almost_empty_n,
  output logic almost_full_n,
  output logic half_full_n,
  output logic output_ready_n,
  output logic input_ready_n,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] HALF_THR = (AW+1)'(DEPTH / 2 + 1);
  localparam logic [AW-1:0] OFS_PAR = AW'(dcf_pkg::OFS_PAR_DEF);
  localparam logic [AW-1:0] OFS_SER = AW'(dcf_pkg::OFS_SER_DEF);

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Declarations
  logic cap_q, fall_q, ld_serial_q;
  logic [AW:0] wptr_q, rptr_q, wptr_s2, rptr_s2;
  logic [AW:0] wcount, rcount, rtotal, ae_thr, af_thr;
  logic [AW-1:0] empty_ofs_q, full_ofs_q;
  logic [W-1:0] mem_rdata, read_data_out_q;
  logic out_valid_q, wr_ok, rd_std, rd_take, load_out;
  logic [2:0] flag_raw, flag_q;
  logic almost_empty_n_q, almost_full_n_q, half_full_n_q, output_ready_n_q;
  dcf_pkg::dcf_wr_state_e wst_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_word;
  logic [3:0] wstrb_q;
  logic commit;

  // ==========================================================
  // Strap capture at the first edge after release; async reset takes constants only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cap_q <= 1'b0;
      fall_q <= 1'b0;
      ld_serial_q <= 1'b0;
    end else if (!cap_q) begin
      cap_q <= 1'b1;
      fall_q <= mode_select_serial_in;
      ld_serial_q <= load_select_n;
    end
  end

  // ==========================================================
  // Pointer crossing; counts are pessimistic on each side
  dcf_sync2 #(.W(AW+1), .RST('0)) u_wsync (
    .clock(clock),
    .resetn(resetn),
    .d(wptr_q),
    .q(wptr_s2)
  );
  dcf_sync2 #(.W(AW+1), .RST('0)) u_rsync (
    .clock(clock),
    .resetn(resetn),
    .d(rptr_q),
    .q(rptr_s2)
  );

  // Words seen by the writer and the reader
  assign wcount = wptr_q - rptr_s2;
  assign rcount = wptr_s2 - rptr_q;
  assign rtotal = rcount + {{AW{1'b0}}, out_valid_q};

  // ==========================================================
  // Write acceptance; a full store refuses the word
  assign wr_ok = cap_q && !wr_en_n && (wcount != FULL_CNT);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wptr_q <= '0;
    end else if (wr_ok) begin
      wptr_q <= wptr_q + 1'b1;
    end
  end

  dcf_store #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_store (
    .clock(clock),
    .we(wr_ok),
    .waddr(wptr_q[AW-1:0]),
    .wdata(wr_data),
    .raddr(rptr_q[AW-1:0]),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // Read side: standard reads on request, fall-through preloads
  assign rd_std = !fall_q && !rd_en_n && (rcount != '0);
  assign rd_take = fall_q && !rd_en_n && out_valid_q;
  assign load_out = fall_q && (rcount != '0) && (!out_valid_q || rd_take);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rptr_q <= '0;
    end else if (rd_std || load_out) begin
      rptr_q <= rptr_q + 1'b1;
    end
  end

  // Output register holds one extra word in fall-through
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_valid_q <= 1'b0;
    end else if (load_out) begin
      out_valid_q <= 1'b1;
    end else if (rd_take) begin
      out_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      read_data_out_q <= '0;
    end else if (rd_std || load_out) begin
      read_data_out_q <= mem_rdata;
    end
  end

  // ==========================================================
  // Empty, full and input-ready through two stages; unused mode parks high
  assign flag_raw[0] = fall_q || (rcount != '0);
  assign flag_raw[1] = fall_q || (wcount != FULL_CNT);
  assign flag_raw[2] = !cap_q || !fall_q || (wcount == FULL_CNT);

  dcf_sync2 #(.W(3), .RST(3'h6)) u_flags (
    .clock(clock),
    .resetn(resetn),
    .d(flag_raw),
    .q(flag_q)
  );

  // ==========================================================
  // Programmable and half flags; fall-through almost-empty counts the output word
  assign ae_thr = {1'b0, empty_ofs_q} + {{AW{1'b0}}, 1'b1} + {{AW{1'b0}}, fall_q};
  assign af_thr = FULL_CNT - {1'b0, full_ofs_q};

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      almost_empty_n_q <= 1'b0;
      almost_full_n_q <= 1'b1;
      half_full_n_q <= 1'b1;
      output_ready_n_q <= 1'b1;
    end else begin
      almost_empty_n_q <= (rtotal >= ae_thr);
      almost_full_n_q <= !(wcount >= af_thr);
      half_full_n_q <= !(wcount >= HALF_THR);
      output_ready_n_q <= !(fall_q && (load_out || (out_valid_q && !rd_take)));
    end
  end

  assign read_data_out = read_data_out_q;
  assign empty_flag_n = flag_q[0];
  assign full_flag_n = flag_q[1];
  assign input_ready_n = flag_q[2];
  assign almost_empty_n = almost_empty_n_q;
  assign almost_full_n = almost_full_n_q;
  assign half_full_n = half_full_n_q;
  assign output_ready_n = output_ready_n_q;

  // ==========================================================
  // Register write channel; address and data taken in either order
  assign commit = (wst_q == dcf_pkg::WR_IDLE) && !awready_q && !wready_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end else if (bvalid_q && s_axi_bready) begin
        awready_q <= 1'b1;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (bvalid_q && s_axi_bready) begin
        wready_q <= 1'b1;
      end
    end
  end

  // Response state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wst_q <= dcf_pkg::WR_IDLE;
      bvalid_q <= 1'b0;
      bresp_q <= dcf_pkg::RESP_OKAY;
    end else begin
      case (wst_q)
        dcf_pkg::WR_IDLE: begin
          if (commit) begin
            wst_q <= dcf_pkg::WR_RESP;
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q == dcf_pkg::REG_EMPTY_OFS || awaddr_q == dcf_pkg::REG_FULL_OFS ||
                        awaddr_q == dcf_pkg::REG_STATUS || awaddr_q == dcf_pkg::REG_COUNT) ?
                       dcf_pkg::RESP_OKAY : dcf_pkg::RESP_DECERR;
          end
        end
        dcf_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wst_q <= dcf_pkg::WR_IDLE;
            bvalid_q <= 1'b0;
          end
        end
        default: begin
          wst_q <= dcf_pkg::WR_IDLE;
          bvalid_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Offsets: strap default at capture, then software may rewrite
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      empty_ofs_q <= OFS_PAR;
      full_ofs_q <= OFS_PAR;
    end else if (!cap_q) begin
      empty_ofs_q <= load_select_n ? OFS_SER : OFS_PAR;
      full_ofs_q <= load_select_n ? OFS_SER : OFS_PAR;
    end else if (commit && awaddr_q == dcf_pkg::REG_EMPTY_OFS) begin
      empty_ofs_q <= AW'(merge({{(32-AW){1'b0}}, empty_ofs_q}, wdata_q, wstrb_q));
    end else if (commit && awaddr_q == dcf_pkg::REG_FULL_OFS) begin
      full_ofs_q <= AW'(merge({{(32-AW){1'b0}}, full_ofs_q}, wdata_q, wstrb_q));
    end
  end

  // ==========================================================
  // Register read channel; status shows the live flags
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      dcf_pkg::REG_EMPTY_OFS: rd_word[AW-1:0] = empty_ofs_q;
      dcf_pkg::REG_FULL_OFS: rd_word[AW-1:0] = full_ofs_q;
      dcf_pkg::REG_STATUS: begin
        rd_word[dcf_pkg::ST_FALL] = fall_q;
        rd_word[dcf_pkg::ST_SERIAL] = ld_serial_q;
        rd_word[dcf_pkg::ST_EMPTY] = flag_q[0];
        rd_word[dcf_pkg::ST_FULL] = flag_q[1];
        rd_word[dcf_pkg::ST_AE] = almost_empty_n_q;
        rd_word[dcf_pkg::ST_AF] = almost_full_n_q;
        rd_word[dcf_pkg::ST_HALF] = half_full_n_q;
        rd_word[dcf_pkg::ST_OR] = output_ready_n_q;
        rd_word[dcf_pkg::ST_INRDY] = flag_q[2];
      end
      dcf_pkg::REG_COUNT: rd_word[AW:0] = rtotal;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= dcf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= (s_axi_araddr == dcf_pkg::REG_EMPTY_OFS || s_axi_araddr == dcf_pkg::REG_FULL_OFS ||
                  s_axi_araddr == dcf_pkg::REG_STATUS || s_axi_araddr == dcf_pkg::REG_COUNT) ?
                 dcf_pkg::RESP_OKAY : dcf_pkg::RESP_DECERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  mode_hold_a: assert property (cap_q && $past(cap_q) |-> $stable(fall_q))
    else $error("timing mode changed after capture");
  std_read_a: assert property (rd_std |=> rptr_q == $past(rptr_q) + 1'b1)
    else $error("standard read did not advance");
  fall_first_a: assert property (fall_q && wr_ok && wptr_q == rptr_q && wptr_s2 == rptr_q && !out_valid_q
    |-> ##4 out_valid_q)
    else $error("first word did not fall through");
  write_take_a: assert property (wr_ok |=> wptr_q == $past(wptr_q) + 1'b1)
    else $error("write not stored");
  empty_pipe_a: assert property (cap_q && $past(cap_q, 2) && !fall_q
    |-> empty_flag_n == ($past(rcount, 2) != '0))
    else $error("empty flag wrong");
  full_pipe_a: assert property (cap_q && $past(cap_q, 2) && !fall_q
    |-> full_flag_n == ($past(wcount, 2) != FULL_CNT))
    else $error("full flag wrong");
  no_overflow_a: assert property (wcount == FULL_CNT |-> !wr_ok)
    else $error("write accepted while full");
  no_underrun_a: assert property (!fall_q && rcount == '0 |=> $stable(rptr_q) && $stable(read_data_out_q))
    else $error("read accepted while empty");
  half_flag_a: assert property (cap_q |=> half_full_n == ($past(wcount) < HALF_THR))
    else $error("half flag wrong");
  ae_flag_a: assert property (cap_q |=> almost_empty_n == ($past(rtotal) >= $past(ae_thr)))
    else $error("almost empty flag wrong");
endmodule
`default_nettype wire

/* File: test/dcf_partner.sv */
// Purpose: Writer and reader logic beside the FIFO
// Assumes: One clock; the bench calls the tasks
// Notes: Idle data lines show the inverse of the last word
`timescale 1ns/100ps
`default_nettype none
module dcf_partner (
  // Clock
  input wire logic clock,
  // Writer
  output logic wr_en_n,
  output logic [dcf_pkg::DATA_W-1:0] wr_data,
  // Reader
  output logic rd_en_n,
  input wire logic [dcf_pkg::DATA_W-1:0] read_data_out
);
  // ==========================================
  // Idle levels
  initial begin
    wr_en_n = 1'b1;
    wr_data = '0;
    rd_en_n = 1'b1;
  end

  // One word per edge; a stale word left on the lines would hide capture slips
  task automatic push(input logic [dcf_pkg::DATA_W-1:0] words[$]);
    @(posedge clock);
    foreach (words[i]) begin
      wr_en_n <= 1'b0;
      wr_data <= words[i];
      @(posedge clock);
    end
    wr_en_n <= 1'b1;
    wr_data <= ~words[words.size()-1];
  endtask

  // Every word asked for by its own enable edge, taken one edge later
  task automatic pop(input int n, output logic [dcf_pkg::DATA_W-1:0] got[$]);
    got = {};
    @(posedge clock);
    rd_en_n <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      @(posedge clock);
      if (i == n - 1) rd_en_n <= 1'b1;
      if (i > 0) got.push_back(read_data_out);
    end
  endtask
endmodule
`default_nettype wire

/* File: test/dcf_fifo_bench.sv */
// Purpose: Self-checking bench for the FIFO flag block
// Assumes: Short depth of 64 words, offsets set over the bus
// Notes: Flags compared only after they have settled
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo_bench;
  localparam int DEPTH = 64;
  localparam int N_OFS = 5;
  localparam int M_OFS = 6;
  logic clock, resetn, mode_select_serial_in, load_select_n;
  logic wr_en_n, rd_en_n;
  logic [dcf_pkg::DATA_W-1:0] wr_data, read_data_out, last;
  logic empty_flag_n, full_flag_n, almost_empty_n, almost_full_n, half_full_n, output_ready_n, input_ready_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [dcf_pkg::DATA_W-1:0] model[$], got[$], q[$];
  int miscompares, checks, seed;

  dcf_fifo #(.DEPTH(DEPTH), .W(dcf_pkg::DATA_W)) u_dcf_fifo (.clock, .resetn, .mode_select_serial_in,
    .load_select_n, .wr_en_n, .wr_data, .rd_en_n, .read_data_out, .empty_flag_n, .full_flag_n,
    .almost_empty_n, .almost_full_n, .half_full_n, .output_ready_n, .input_ready_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dcf_partner u_dcf_partner (.clock, .wr_en_n, .wr_data, .rd_en_n, .read_data_out);

  // ==========================================
  // Clock and time-zero values
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    resetn = 1'b0;
    mode_select_serial_in = 1'b0;
    load_select_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end

  // ==========================================
  // Comparisons and verdict
  task automatic report(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    report(g, e);
  endtask
  task automatic cmp_data(input logic [dcf_pkg::DATA_W-1:0] g, input logic [dcf_pkg::DATA_W-1:0] e);
    report(32'(g), 32'(e));
  endtask
  task automatic cmp_flags(input logic [4:0] g, input logic [4:0] e);
    report(32'(g), 32'(e));
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    finish_test();
  end

  // ==========================================
  // Register bus master; readies are waited on, never assumed
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // ==========================================
  // Model flags: {full, almost full, half full, almost empty, empty}
  function automatic logic [4:0] exp_flags(input int c);
    return {c != DEPTH, c < DEPTH - M_OFS, c < DEPTH / 2 + 1, c >= N_OFS + 1, c != 0};
  endfunction
  task automatic check_state();
    repeat (8) @(posedge clock);
    cmp_flags({full_flag_n, almost_full_n, half_full_n, almost_empty_n, empty_flag_n},
      exp_flags(model.size()));
    axi_rd(dcf_pkg::REG_COUNT, d, r);
    cmp_reg(d, 32'(model.size()));
  endtask
  // Straps held steady across the whole reset
  task automatic do_reset(input logic mode, input logic load);
    @(posedge clock);
    resetn <= 1'b0;
    mode_select_serial_in <= mode;
    load_select_n <= load;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    model = {};
  endtask

  // ==========================================
  // Main sequence
  initial begin
    seed = 32'h2168;
    do_reset(1'b0, 1'b0);
    cmp_flags({full_flag_n, almost_full_n, half_full_n, almost_empty_n, empty_flag_n}, 5'b11100);
    axi_rd(dcf_pkg::REG_STATUS, d, r);
    cmp_reg(d & 32'h3, 32'h0);
    axi_rd(dcf_pkg::REG_EMPTY_OFS, d, r);
    cmp_reg(d, 32'(127 % DEPTH));
    axi_wr(8'h40, 32'h0, r);
    cmp_reg(32'(r), 32'(dcf_pkg::RESP_DECERR));
    axi_rd(8'h40, d, r);
    cmp_reg(32'(r), 32'(dcf_pkg::RESP_DECERR));
    axi_wr(dcf_pkg::REG_STATUS, 32'hffff, r);
    cmp_reg(32'(r), 32'(dcf_pkg::RESP_OKAY));
    axi_wr(dcf_pkg::REG_EMPTY_OFS, 32'(N_OFS), r);
    axi_wr(dcf_pkg::REG_FULL_OFS, 32'(M_OFS), r);
    axi_rd(dcf_pkg::REG_FULL_OFS, d, r);
    cmp_reg(d, 32'(M_OFS));
    u_dcf_partner.pop(2, got);
    cmp_data(read_data_out, '0);
    // Fill one word at a time; the last push meets a full FIFO
    for (int k = 0; k <= DEPTH; k++) begin
      last = dcf_pkg::DATA_W'($random(seed));
      u_dcf_partner.push({last});
      if (k < DEPTH) model.push_back(last);
      check_state();
    end
    // Drain one word at a time, flags released on the way down
    for (int k = 0; k < DEPTH; k++) begin
      u_dcf_partner.pop(1, got);
      last = model.pop_front();
      cmp_data(got[0], last);
      check_state();
    end
    u_dcf_partner.pop(1, got);
    cmp_data(got[0], last);
    // Writer and reader busy at once
    q = {};
    repeat (30) q.push_back(dcf_pkg::DATA_W'($random(seed)));
    model = q;
    fork
      u_dcf_partner.push(q);
      begin
        repeat (8) @(posedge clock);
        u_dcf_partner.pop(20, got);
      end
    join
    foreach (got[i]) cmp_data(got[i], model.pop_front());
    check_state();
    // Fall-through mode with serial default offsets
    do_reset(1'b1, 1'b1);
    axi_rd(dcf_pkg::REG_STATUS, d, r);
    cmp_reg(d & 32'h3, 32'h3);
    axi_rd(dcf_pkg::REG_EMPTY_OFS, d, r);
    cmp_reg(d, 32'(1023 % DEPTH));
    cmp_flags({1'b0, empty_flag_n, full_flag_n, output_ready_n, input_ready_n}, 5'b01110);
    last = dcf_pkg::DATA_W'($random(seed));
    u_dcf_partner.push({last});
    repeat (6) @(posedge clock);
    cmp_data(read_data_out, last);
    cmp_flags({4'h0, output_ready_n}, 5'b00000);
    u_dcf_partner.pop(1, got);
    repeat (6) @(posedge clock);
    cmp_flags({4'h0, output_ready_n}, 5'b00001);
    q = {};
    repeat (70) q.push_back(dcf_pkg::DATA_W'($random(seed)));
    u_dcf_partner.push(q);
    repeat (8) @(posedge clock);
    cmp_flags({4'h0, input_ready_n}, 5'b00001);
    axi_rd(dcf_pkg::REG_COUNT, d, r);
    cmp_reg(d, 32'(DEPTH + 1));
    finish_test();
  end
endmodule
`default_nettype wire
